//--- hdl/bma_bit_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "bma_cfg.svh"

module bma_bit_timer #(
    parameter int BIT_CYCLES = `BMA_BIT_CYCLES
) (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Bus idle pin.
    input  wire logic       bus_idle_pin,
    // Timing outputs.
    output logic            bus_idle,
    output logic            bit_tick,
    output logic [7:0]      idle_bits
);
    logic        idle_meta_q;
    logic [15:0] div_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            idle_meta_q <= 1'b0;
            bus_idle    <= 1'b0;
        end else begin
            idle_meta_q <= bus_idle_pin;
            bus_idle    <= idle_meta_q;
        end
    end

    // The divider restarts when the bus goes busy, so idle bit counts are whole bits.
    always_ff @(posedge ref_clk) begin
        if (rst || !bus_idle) begin
            div_q    <= 16'h0000;
            bit_tick <= 1'b0;
        end else if (div_q == 16'(BIT_CYCLES - 1)) begin
            div_q    <= 16'h0000;
            bit_tick <= 1'b1;
        end else begin
            div_q    <= div_q + 16'h0001;
            bit_tick <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !bus_idle) begin
            idle_bits <= 8'h00;
        end else if (bit_tick && idle_bits != 8'hff) begin
            idle_bits <= idle_bits + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- hdl/bma_cfg.svh
`ifndef BMA_CFG_SVH
`define BMA_CFG_SVH

// Register byte offsets on the AXI4-Lite slave.
`define BMA_REG_CTRL        8'h00
`define BMA_REG_ADDR        8'h04
`define BMA_REG_REP         8'h08
`define BMA_REG_CFG         8'h0c
`define BMA_REG_STAT        8'h10
`define BMA_ADDR_LSB        2
`define BMA_ADDR_MSB        7

// Command bits of the control register (write one to issue).
`define BMA_CTRL_RESET      0
`define BMA_CTRL_MONITOR    1
`define BMA_CTRL_BUSY_ON    2
`define BMA_CTRL_BUSY_OFF   3
`define BMA_CTRL_HOST_ACK   4

// Set-repetition byte fields and the reset limit.
`define BMA_REP_BUSY_LSB    4
`define BMA_REP_NEGATIVE_BUS_ACK_LSB    0
`define BMA_REP_DEFAULT     3'h3

// Feature bits of the configure register.
`define BMA_CFG_MARK        0
`define BMA_CFG_CRC         1
`define BMA_CFG_POLL        2

// Configuration-status indication layout.
`define BMA_IND_BASE        8'h01
`define BMA_IND_MARK        2
`define BMA_IND_CRC         3
`define BMA_IND_POLL        4
`define BMA_IND_AA          5
`define BMA_IND_BUSY        6

// Acknowledge kinds reported by the transmit path.
`define BMA_ACKK_POS        2'h0
`define BMA_ACKK_BUSY       2'h1
`define BMA_ACKK_NEGATIVE_BUS_ACK       2'h2

// Acknowledge bytes placed on the bus.
`define BMA_ACK_POS         8'hcc
`define BMA_ACK_NEGATIVE_BUS_ACK        8'h0c
`define BMA_ACK_BUSY        8'hc0

// Timing, in nanoseconds and bit times.
`define BMA_CLK_NS          10
`define BMA_BIT_NS          104167
`define BMA_BIT_CYCLES      (`BMA_BIT_NS / `BMA_CLK_NS)
`define BMA_BUSY_GAP_BITS   8'd150
`define BMA_NEGATIVE_BUS_ACK_GAP_BITS   8'd50
`define BMA_ACK_TMO_BITS    8'd30

// Bus responses.
`define BMA_RESP_OKAY       2'h0
`define BMA_RESP_SLVERR     2'h2

`endif

//--- hdl/bma_ctrl.sv
// Operation
// [RULE1] Bus monitor mode forwards every received bus byte to host, unfiltered.
// [RULE2] In bus monitor mode acknowledge bytes also go to the host unchanged.
// [RULE3] Bus monitor mode lasts until the reset service; nothing else leaves it.
// [RULE4] Set-address stores the individual address and switches auto-acknowledge on.
// [RULE5] Auto-acknowledge answers positive for own individual or group destination frames.
// [RULE6] An error in such a received frame gives a negative acknowledge instead.
// [RULE7] A repeated set-address only overwrites the stored address.
// [RULE8] Turning auto-acknowledge on sends the configuration-status indication to the host.
// [RULE9] Set-address accepted anytime; address and auto-acknowledge apply at bus idle.
// [RULE10] Auto-acknowledge stays on until the reset service.
// [RULE11] The dummy byte of set-address is ignored.
// [RULE12] Two retry limits, busy and negative, both 3 after reset.
// [RULE13] After busy acknowledge resend after 150 idle bit times, within busy limit.
// [RULE14] Busy acknowledge after the last retry gives a negative data confirmation.
// [RULE15] No acknowledge within 30 bit times after a frame is a timeout.
// [RULE16] Negative, invalid acknowledge or timeout resends after 50 idle bits, within limit.
// [RULE17] Exhausted retry limit stops resending and returns negative confirmation.
// [RULE18] Set-repetition carries a 3-bit busy count and a 3-bit negative count.
// [RULE19] Host keeps bits 3 and 7 of the second set-repetition byte zero.
// [RULE20] Status indication reports busy flag: set by busy-on, cleared by busy-off or ack; the code ignores busy-on while auto-acknowledge is off.
// [RULE21] Status indication reports auto-ack, auto-poll, checksum and marker flags.
// [RULE22] Outside bus monitor mode acknowledge bytes are withheld from the host.
// [RULE23] Busy mode with auto-acknowledge answers own-address frames with busy acknowledge.
// [RULE24] Both retry counters reload from the limits at each new host transmission.
// [RULE25] Retry limits change only by set-repetition or the reset service.
`timescale 1ns/1ns
`default_nettype none
`include "bma_cfg.svh"

module bma_ctrl #(
    parameter int BIT_CYCLES = `BMA_BIT_CYCLES
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AXI4-Lite write address and data.
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Bus receive path.
    input  wire logic        bus_idle_pin,
    input  wire logic        rx_byte_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_is_ack,
    input  wire logic        rx_frame_end,
    input  wire logic [15:0] rx_dest_addr,
    input  wire logic        rx_dest_group,
    input  wire logic        rx_frame_error,
    // Bus acknowledge output.
    output logic             ack_valid,
    output logic [7:0]       ack_byte,
    // Bus transmit path.
    input  wire logic        tx_start,
    input  wire logic        tx_frame_done,
    input  wire logic        tx_ack_valid,
    input  wire logic [1:0]  tx_ack_kind,
    output logic             tx_repeat,
    // Host service output.
    output logic             host_byte_valid,
    output logic [7:0]       host_byte,
    output logic             cfg_ind_valid,
    output logic [7:0]       cfg_ind_byte,
    output logic             con_valid,
    output logic             con_positive
);
    localparam int NREG = 5;

    function automatic logic [2:0] reg_index(input logic [7:0] a);
        if (a == `BMA_REG_CTRL) begin
            reg_index = 3'h0;
        end else if (a == `BMA_REG_ADDR) begin
            reg_index = 3'h1;
        end else if (a == `BMA_REG_REP) begin
            reg_index = 3'h2;
        end else if (a == `BMA_REG_CFG) begin
            reg_index = 3'h3;
        end else if (a == `BMA_REG_STAT) begin
            reg_index = 3'h4;
        end else begin
            reg_index = 3'h7;
        end
    endfunction

    logic        bus_idle;
    logic        bit_tick;
    logic [7:0]  idle_bits;

    bma_bit_timer #(.BIT_CYCLES(BIT_CYCLES)) u_timer (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .bus_idle_pin (bus_idle_pin),
        .bus_idle     (bus_idle),
        .bit_tick     (bit_tick),
        .idle_bits    (idle_bits)
    );

    // Register slave.
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_en;
    logic [2:0]  wr_idx;

    assign wr_en  = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_idx = reg_index(aw_addr_q);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BMA_RESP_OKAY;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_have_q) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_have_q) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_idx == 3'h7) ? `BMA_RESP_SLVERR : `BMA_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
            end
        end
    end

    // Write pulses of each command, lane 0 must be enabled.
    logic       wr_ok;
    logic [7:0] cmd;
    assign wr_ok = wr_en && w_strb_q[0];
    assign cmd   = (wr_ok && wr_idx == 3'h0) ? w_data_q[7:0] : 8'h00;

    logic soft_rst;
    assign soft_rst = rst || cmd[`BMA_CTRL_RESET];

    // Mode and feature state.
    logic        monitor_q;
    logic        aa_q;
    logic        busy_q;
    logic [2:0]  feat_q;
    logic        addr_pend_q;
    logic [15:0] addr_new_q;
    logic [15:0] addr_q;
    logic [2:0]  lim_busy_q;
    logic [2:0]  lim_negative_bus_ack_q;

    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            monitor_q <= 1'b0;
        end else if (cmd[`BMA_CTRL_MONITOR]) begin
            monitor_q <= 1'b1; // RULE3
        end
    end

    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            busy_q <= 1'b0;
        end else if (cmd[`BMA_CTRL_BUSY_OFF] || cmd[`BMA_CTRL_HOST_ACK]) begin
            busy_q <= 1'b0; // RULE20
        end else if (cmd[`BMA_CTRL_BUSY_ON] && aa_q) begin
            busy_q <= 1'b1; // RULE20
        end
    end

    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            feat_q <= 3'h0;
        end else if (wr_ok && wr_idx == 3'h3) begin
            feat_q <= feat_q | w_data_q[2:0];
        end
    end

    // The request is parked until the bus is idle; the dummy byte lane is never read.
    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            addr_pend_q <= 1'b0;
            addr_new_q  <= 16'h0000;
            addr_q      <= 16'h0000;
            aa_q        <= 1'b0;
        end else if (wr_ok && w_strb_q[1] && wr_idx == 3'h1) begin
            addr_pend_q <= 1'b1; // RULE9
            addr_new_q  <= w_data_q[15:0]; // RULE11
        end else if (addr_pend_q && bus_idle) begin
            addr_pend_q <= 1'b0;
            addr_q      <= addr_new_q; // RULE4 RULE7
            aa_q        <= 1'b1; // RULE4 RULE10
        end
    end

    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            lim_busy_q <= `BMA_REP_DEFAULT; // RULE12
            lim_negative_bus_ack_q <= `BMA_REP_DEFAULT; // RULE12
        end else if (wr_ok && wr_idx == 3'h2) begin
            lim_busy_q <= w_data_q[`BMA_REP_BUSY_LSB +: 3]; // RULE18 RULE25
            lim_negative_bus_ack_q <= w_data_q[`BMA_REP_NEGATIVE_BUS_ACK_LSB +: 3]; // RULE18 RULE25
        end
    end

    // Configuration-status indication on auto-acknowledge activation.
    logic [7:0] ind_now;
    always_comb begin
        ind_now = `BMA_IND_BASE;
        ind_now[`BMA_IND_BUSY] = busy_q; // RULE20
        ind_now[`BMA_IND_AA]   = 1'b1; // RULE21
        ind_now[`BMA_IND_POLL] = feat_q[`BMA_CFG_POLL]; // RULE21
        ind_now[`BMA_IND_CRC]  = feat_q[`BMA_CFG_CRC]; // RULE21
        ind_now[`BMA_IND_MARK] = feat_q[`BMA_CFG_MARK]; // RULE21
    end

    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            cfg_ind_valid <= 1'b0;
            cfg_ind_byte  <= 8'h00;
        end else begin
            cfg_ind_valid <= addr_pend_q && bus_idle && !aa_q; // RULE8
            if (addr_pend_q && bus_idle && !aa_q) begin
                cfg_ind_byte <= ind_now; // RULE8
            end
        end
    end

    a_aa_notify: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE8
        $rose(aa_q) |-> cfg_ind_valid && cfg_ind_byte[`BMA_IND_AA])
        else $error("auto-ack activation not indicated");
    a_aa_sticky: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE10
        aa_q |=> aa_q)
        else $error("auto-ack dropped without reset");
    a_aa_idle: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE9
        $changed(addr_q) && aa_q |-> $past(bus_idle))
        else $error("address applied while bus busy");

    // Forwarding of received bytes to the host.
    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            host_byte_valid <= 1'b0;
            host_byte       <= 8'h00;
        end else begin
            host_byte_valid <= rx_byte_valid && (monitor_q || !rx_is_ack); // RULE1 RULE2 RULE22
            if (rx_byte_valid) begin
                host_byte <= rx_byte; // RULE1 RULE2
            end
        end
    end

    a_mon_fwd: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE1
        monitor_q && rx_byte_valid |=> host_byte_valid && host_byte == $past(rx_byte))
        else $error("monitor byte not forwarded");
    a_ack_withheld: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE22
        !monitor_q && rx_byte_valid && rx_is_ack |=> !host_byte_valid)
        else $error("ack byte leaked outside monitor mode");

    // Automatic acknowledge of received frames; monitor mode only listens.
    logic own_hit;
    assign own_hit = rx_dest_addr == addr_q && !rx_dest_group;

    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            ack_valid <= 1'b0;
            ack_byte  <= 8'h00;
        end else begin
            ack_valid <= 1'b0;
            if (rx_frame_end && aa_q && !monitor_q && (own_hit || rx_dest_group)) begin // RULE5
                ack_valid <= 1'b1;
                if (rx_frame_error) begin
                    ack_byte <= `BMA_ACK_NEGATIVE_BUS_ACK; // RULE6
                end else if (busy_q && own_hit) begin
                    ack_byte <= `BMA_ACK_BUSY; // RULE23
                end else begin
                    ack_byte <= `BMA_ACK_POS; // RULE5
                end
            end
        end
    end

    a_ack_err: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE6
        rx_frame_end && aa_q && !monitor_q && (own_hit || rx_dest_group) && rx_frame_error
        |=> ack_valid && ack_byte == `BMA_ACK_NEGATIVE_BUS_ACK)
        else $error("erroneous frame not negatively acknowledged");

    // Transmit retry engine.
    bma_pkg::bma_tx_state_t tx_state_q;
    logic [2:0] busy_cnt_q;
    logic [2:0] negative_bus_ack_cnt_q;
    logic [7:0] gap_q;
    logic [7:0] tmo_q;
    logic       ack_busy;
    logic       ack_pos;
    logic       timeout;

    assign ack_pos  = tx_ack_valid && tx_ack_kind == `BMA_ACKK_POS;
    assign ack_busy = tx_ack_valid && tx_ack_kind == `BMA_ACKK_BUSY;
    assign timeout  = !tx_ack_valid && tmo_q == `BMA_ACK_TMO_BITS; // RULE15

    always_ff @(posedge ref_clk) begin
        if (soft_rst || tx_state_q != bma_pkg::TX_WAIT_ACK) begin
            tmo_q <= 8'h00;
        end else if (bit_tick) begin
            tmo_q <= tmo_q + 8'h01; // RULE15
        end
    end

    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            tx_state_q   <= bma_pkg::TX_IDLE;
            busy_cnt_q   <= 3'h0;
            negative_bus_ack_cnt_q   <= 3'h0;
            gap_q        <= 8'h00;
            tx_repeat    <= 1'b0;
            con_valid    <= 1'b0;
            con_positive <= 1'b0;
        end else begin
            tx_repeat <= 1'b0;
            con_valid <= 1'b0;
            case (tx_state_q)
                bma_pkg::TX_IDLE: begin
                    if (tx_start) begin
                        busy_cnt_q <= lim_busy_q; // RULE24
                        negative_bus_ack_cnt_q <= lim_negative_bus_ack_q; // RULE24
                        tx_state_q <= bma_pkg::TX_SENDING;
                    end
                end
                bma_pkg::TX_SENDING: begin
                    if (tx_frame_done) begin
                        tx_state_q <= bma_pkg::TX_WAIT_ACK;
                    end
                end
                bma_pkg::TX_WAIT_ACK: begin
                    if (ack_pos) begin
                        con_valid    <= 1'b1;
                        con_positive <= 1'b1;
                        tx_state_q   <= bma_pkg::TX_IDLE;
                    end else if (ack_busy) begin
                        if (busy_cnt_q == 3'h0) begin
                            con_valid    <= 1'b1; // RULE14 RULE17
                            con_positive <= 1'b0;
                            tx_state_q   <= bma_pkg::TX_IDLE;
                        end else begin
                            busy_cnt_q <= busy_cnt_q - 3'h1;
                            gap_q      <= `BMA_BUSY_GAP_BITS; // RULE13
                            tx_state_q <= bma_pkg::TX_WAIT_GAP;
                        end
                    end else if (tx_ack_valid || timeout) begin
                        if (negative_bus_ack_cnt_q == 3'h0) begin
                            con_valid    <= 1'b1; // RULE17
                            con_positive <= 1'b0;
                            tx_state_q   <= bma_pkg::TX_IDLE;
                        end else begin
                            negative_bus_ack_cnt_q <= negative_bus_ack_cnt_q - 3'h1;
                            gap_q      <= `BMA_NEGATIVE_BUS_ACK_GAP_BITS; // RULE16
                            tx_state_q <= bma_pkg::TX_WAIT_GAP;
                        end
                    end
                end
                bma_pkg::TX_WAIT_GAP: begin
                    if (bus_idle && idle_bits >= gap_q) begin
                        tx_repeat  <= 1'b1; // RULE13 RULE16
                        tx_state_q <= bma_pkg::TX_SENDING;
                    end
                end
                default: begin
                    tx_state_q <= bma_pkg::TX_IDLE;
                end
            endcase
        end
    end

    a_rep_gap: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE16
        $rose(tx_repeat) |-> $past(idle_bits) >= `BMA_NEGATIVE_BUS_ACK_GAP_BITS && $past(bus_idle))
        else $error("frame repeated without idle gap");
    a_busy_last: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE14
        tx_state_q == bma_pkg::TX_WAIT_ACK && ack_busy && busy_cnt_q == 3'h0
        |=> con_valid && !con_positive ##1 !con_valid)
        else $error("no negative confirmation after busy retries");
    a_tmo_retry: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE15
        tx_state_q == bma_pkg::TX_WAIT_ACK && timeout && negative_bus_ack_cnt_q != 3'h0
        |=> tx_state_q == bma_pkg::TX_WAIT_GAP && gap_q == `BMA_NEGATIVE_BUS_ACK_GAP_BITS)
        else $error("timeout not treated as negative ack");
    a_reload: assert property (@(posedge ref_clk) disable iff (soft_rst) // RULE24
        tx_state_q == bma_pkg::TX_IDLE && tx_start
        |=> busy_cnt_q == $past(lim_busy_q) && negative_bus_ack_cnt_q == $past(lim_negative_bus_ack_q))
        else $error("retry counters not reloaded");

    // Register read.
    logic [31:0] rd_word;
    logic [2:0]  rd_idx;
    assign rd_idx = reg_index(s_axi_araddr);

    always_comb begin
        rd_word = 32'h0000_0000;
        if (rd_idx == 3'h1) begin
            rd_word[15:0] = addr_q;
        end else if (rd_idx == 3'h2) begin
            rd_word[`BMA_REP_BUSY_LSB +: 3] = lim_busy_q;
            rd_word[`BMA_REP_NEGATIVE_BUS_ACK_LSB +: 3] = lim_negative_bus_ack_q;
        end else if (rd_idx == 3'h3) begin
            rd_word[2:0] = feat_q;
        end else if (rd_idx == 3'h4) begin
            rd_word[7:0]   = aa_q ? ind_now : (ind_now & ~(8'h01 << `BMA_IND_AA));
            rd_word[8]     = monitor_q;
            rd_word[9]     = addr_pend_q;
            rd_word[12:10] = tx_state_q;
            rd_word[15:13] = busy_cnt_q;
            rd_word[18:16] = negative_bus_ack_cnt_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BMA_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_idx == 3'h7) ? `BMA_RESP_SLVERR : `BMA_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- hdl/bma_pkg.sv
package bma_pkg;
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_SENDING,
        TX_WAIT_ACK,
        TX_WAIT_GAP
    } bma_tx_state_t;
endpackage

//--- verification/bma_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module bma_bus_model (
    input  wire logic ref_clk,
    output logic bus_idle_pin, rx_byte_valid, rx_is_ack, rx_frame_end,
    output logic rx_dest_group, rx_frame_error, tx_frame_done, tx_ack_valid,
    output logic [7:0] rx_byte,
    output logic [15:0] rx_dest_addr,
    output logic [1:0] tx_ack_kind
);
    initial begin
        {bus_idle_pin, rx_byte_valid, rx_is_ack, rx_frame_end} = 4'h8;
        {rx_dest_group, rx_frame_error, tx_frame_done, tx_ack_valid} = 4'h0;
        {rx_byte, rx_dest_addr, tx_ack_kind} = 26'h0;
    end
    task automatic hold(input logic i);
        @(posedge ref_clk) bus_idle_pin <= i;
    endtask
    task automatic rx(input logic [7:0] b, input logic a);
        @(posedge ref_clk) {rx_byte_valid, rx_byte, rx_is_ack} <= {1'h1, b, a};
        @(posedge ref_clk) {rx_byte_valid, rx_byte, rx_is_ack} <= {1'h0, ~b, ~a};
    endtask
    task automatic frm(input logic [15:0] d, input logic g, e);
        @(posedge ref_clk) {rx_frame_end, rx_dest_addr, rx_dest_group, rx_frame_error} <= {1'h1, d, g, e};
        @(posedge ref_clk) {rx_frame_end, rx_dest_addr} <= {1'h0, ~d};
    endtask
    // Bus stays busy from frame end until the answer arrives.
    task automatic tx(input logic [1:0] k);
        @(posedge ref_clk) {bus_idle_pin, tx_frame_done} <= 2'h1;
        @(posedge ref_clk) tx_frame_done <= 1'h0;
        repeat (8) @(posedge ref_clk);
        {tx_ack_valid, tx_ack_kind} <= {1'h1, k};
        @(posedge ref_clk) {tx_ack_valid, tx_ack_kind, bus_idle_pin} <= {1'h0, ~k, 1'h1};
    endtask
endmodule
`default_nettype wire

//--- verification/bma_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bma_ctrl_tb;
    logic ref_clk = 1'h0, rst = 1'h1, tx_start = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ack_q = 8'h00, hb_q = 8'h00, ind_q = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, con_positive;
    wire logic ack_valid, tx_repeat, host_byte_valid, cfg_ind_valid, con_valid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, tx_ack_kind;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0] ack_byte, host_byte, cfg_ind_byte, rx_byte;
    wire logic bus_idle_pin, rx_byte_valid, rx_is_ack, rx_frame_end, rx_dest_group, rx_frame_error;
    wire logic tx_frame_done, tx_ack_valid;
    wire logic [15:0] rx_dest_addr;
    int err_count = 0, tests_run = 0, inds = 0, reps = 0, cons = 0;
    logic conp = 1'h1;
    bma_ctrl #(.BIT_CYCLES(4)) u_dut (.*);
    bma_bus_model u_bus (.*);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (ack_valid) ack_q <= ack_byte;
        if (host_byte_valid) hb_q <= host_byte;
        if (cfg_ind_valid) {ind_q, inds} <= {cfg_ind_byte, inds + 1};
        if (tx_repeat) reps <= reps + 1;
        if (con_valid) {conp, cons} <= {con_positive, cons + 1};
    end
    task ck(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s exp %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge ref_clk) {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        ck("bresp", 32'(s_axi_bresp), 32'(r));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk) {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        ck("rdata", s_axi_rdata, e);
        ck("rresp", 32'(s_axi_rresp), 32'h0);
    endtask
    task ak(input logic [15:0] d, input logic g, e, input logic [7:0] x);
        u_bus.frm(d, g, e);
        repeat (3) @(posedge ref_clk);
        ck("ack_byte", 32'(ack_q), 32'(x));
    endtask
    task t_addr;
        rd(8'h08, 32'h33);
        wr(8'h40, 32'h1, 2'h2);
        u_bus.hold(1'h0);
        wr(8'h04, 32'h00ab1234, 2'h0);
        repeat (10) @(posedge ref_clk);
        ck("ind_count", 32'(inds), 32'h0);
        u_bus.hold(1'h1);
        repeat (6) @(posedge ref_clk);
        ck("ind_byte", 32'(ind_q), 32'h21);
        wr(8'h04, 32'h00ff5678, 2'h0);
        repeat (6) @(posedge ref_clk);
        ck("ind_count", 32'(inds), 32'h1);
        rd(8'h04, 32'h5678);
        $display("addr test done");
    endtask
    task t_ack;
        ak(16'h5678, 1'h0, 1'h0, 8'hcc);
        ak(16'h5678, 1'h0, 1'h1, 8'h0c);
        ak(16'h0001, 1'h1, 1'h0, 8'hcc);
        $display("ack test done");
    endtask
    task t_rtx;
        wr(8'h08, 32'h01, 2'h0);
        rd(8'h08, 32'h01);
        @(posedge ref_clk) tx_start <= 1'h1;
        @(posedge ref_clk) tx_start <= 1'h0;
        u_bus.tx(2'h2);
        repeat (190) @(posedge ref_clk);
        ck("repeats", 32'(reps), 32'h0);
        repeat (30) @(posedge ref_clk);
        ck("repeats", 32'(reps), 32'h1);
        u_bus.tx(2'h2);
        @(posedge ref_clk) tx_start <= 1'h1;
        @(posedge ref_clk) tx_start <= 1'h0;
        u_bus.tx(2'h1);
        repeat (230) @(posedge ref_clk);
        ck("con", 32'({reps[1:0], cons[1:0], conp}), 32'h0c);
        $display("retry test done");
    endtask
    task t_mon;
        u_bus.rx(8'h5a, 1'h0);
        u_bus.rx(8'hcc, 1'h1);
        repeat (3) @(posedge ref_clk);
        ck("host_byte", 32'(hb_q), 32'h5a);
        wr(8'h00, 32'h02, 2'h0);
        u_bus.rx(8'hcc, 1'h1);
        repeat (3) @(posedge ref_clk);
        ck("host_byte", 32'(hb_q), 32'hcc);
        $display("monitor test done");
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        t_addr;
        t_ack;
        t_rtx;
        t_mon;
        print_verdict;
    end
endmodule
`default_nettype wire
